// ==== core/hpt_pkg.sv ====
// constants and types shared by the host port and its pin synchroniser
package hpt_pkg;

  // ----------------------------------------
  // data bus and pin bundle layout
  // ----------------------------------------
  localparam int HPT_DATA_W = 16;
  localparam int HPT_ADDR_W = 3;
  localparam int HPT_CHANS = 4;
  localparam int HPT_PIN_W = 23;
  localparam int HPT_PIN_DATA_LSB = 0;
  localparam int HPT_PIN_ADDR_LSB = 16;
  localparam int HPT_PIN_RDRW = 19;
  localparam int HPT_PIN_STROBE = 20;
  localparam int HPT_PIN_CS_N = 21;
  localparam int HPT_PIN_MODE = 22;

  // ----------------------------------------
  // location decode (low two address bits)
  // ----------------------------------------
  localparam logic [1:0] HPT_LOC_HOLD = 2'h0;
  localparam logic [1:0] HPT_LOC_IRQ_LEN = 2'h1;
  localparam logic [1:0] HPT_LOC_IRQ_CFG = 2'h2;
  localparam logic [1:0] HPT_LOC_CHAN = 2'h3;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int HPT_CFG_IRQ_CH_LSB = 0;
  localparam int HPT_CFG_RD_CH_LSB = 2;
  localparam logic [15:0] HPT_HOLD_RST = 16'h0000;
  localparam logic [15:0] HPT_IRQ_LEN_RST = 16'h0001;
  localparam logic [15:0] HPT_IRQ_CFG_RST = 16'h0000;
  localparam logic [22:0] HPT_PIN_RST = 23'h380000;

  // ----------------------------------------
  // bus state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    HPT_BUS_IDLE = 3'b001,
    HPT_BUS_READ = 3'b010,
    HPT_BUS_WRITE = 3'b100
  } hpt_bus_t;

endpackage

// ==== core/hpt_pin_if.sv ====
// carrier between the host port core and its pin synchroniser
`timescale 1ns/1ns
`default_nettype none
interface hpt_pin_if #(parameter int W = 23);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport syncr (input raw, output stable);
  modport core (output raw, input stable);
endinterface
`default_nettype wire

// ==== core/hpt_pin_sync.sv ====
// three-stage pin synchroniser, accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module hpt_pin_sync
  import hpt_pkg::*;
#(
  parameter int W = HPT_PIN_W,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins in, filtered pins out
  hpt_pin_if.syncr pins
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] q;
  logic [W-1:0] next_q;

  // per bit: take stage three only where two and three agree
  always_comb
  begin
    next_q = q;
    for (int i = 0; i < W; i++)
    begin
      if (s2[i] == s3[i])
      begin
        next_q[i] = s3[i];
      end
    end
  end

  // register the chain
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      s1 <= pins.raw;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end

  assign pins.stable = q;

  // filtered value never moves against agreeing stages
  sync_agree_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s2 == s3) |=> (q == $past(s3)))
    else $error("synchroniser output ignored agreeing stages");

endmodule
`default_nettype wire

// ==== core/hpt_host_port.sv ====
// dual strobe-style parallel host port with holding register and timed interrupt
// ----------------------------------------
// Function
// - separate strobes: write on store strobe rise
// - separate strobes: drive bus while read, select low
// - single strobe, direction low: write on rise
// - single strobe, direction high: drive while low
// - mode pin picks style, low by default
// - address top bit ignored, two bits decoded
// - interrupt pulse lasts programmed cycle count, one cycle if zero
// - sixteen bit two-way bus, bit 15 MSB
// - channel samples readable only when synchronised
// ----------------------------------------
`timescale 1ns/1ns
`default_nettype none
module hpt_host_port
  import hpt_pkg::*;
#(
  parameter int IRQ_LEN_W = 8
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host pins
  input wire logic [HPT_DATA_W-1:0] p_in,
  output logic [HPT_DATA_W-1:0] p_out,
  output logic p_oe_n,
  input wire logic [HPT_ADDR_W-1:0] addr,
  input wire logic data_strobe,
  input wire logic rd_rw,
  input wire logic cs_n,
  input wire logic mode_sel,
  // channel datapath side
  input wire logic [HPT_CHANS*HPT_DATA_W-1:0] chan_data,
  input wire logic [HPT_CHANS-1:0] chan_new,
  input wire logic [HPT_CHANS-1:0] chan_synced,
  // target register write port
  output logic tgt_we,
  output logic [1:0] tgt_addr,
  output logic [HPT_DATA_W-1:0] tgt_data,
  // interrupt
  output logic new_data_irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // only the low two address bits select a location
  function automatic logic [1:0] loc_of(input logic [HPT_ADDR_W-1:0] a);
    return a[1:0];
  endfunction

  // pick one 16-bit channel sample
  function automatic logic [HPT_DATA_W-1:0] chan_word(
    input logic [HPT_CHANS*HPT_DATA_W-1:0] d, input logic [1:0] ch);
    return d[ch*HPT_DATA_W +: HPT_DATA_W];
  endfunction

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  hpt_pin_if #(.W(HPT_PIN_W)) pins ();

  assign pins.raw = {mode_sel, cs_n, data_strobe, rd_rw, addr, p_in};

  hpt_pin_sync #(.W(HPT_PIN_W), .RST_VAL(HPT_PIN_RST)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pins(pins)
  );

  logic mode_s;
  logic cs_n_s;
  logic strobe_s;
  logic rdrw_s;
  logic [HPT_ADDR_W-1:0] addr_s;
  logic [HPT_DATA_W-1:0] p_s;
  logic strobe_d;

  assign mode_s = pins.stable[HPT_PIN_MODE];
  assign cs_n_s = pins.stable[HPT_PIN_CS_N];
  assign strobe_s = pins.stable[HPT_PIN_STROBE];
  assign rdrw_s = pins.stable[HPT_PIN_RDRW];
  assign addr_s = pins.stable[HPT_PIN_ADDR_LSB +: HPT_ADDR_W];
  assign p_s = pins.stable[HPT_PIN_DATA_LSB +: HPT_DATA_W];

  // ----------------------------------------
  // transfer decode
  // ----------------------------------------
  logic strobe_rise;
  logic wr_fire;
  logic read_req;
  logic [1:0] loc;

  assign loc = loc_of(addr_s);
  assign strobe_rise = strobe_s && !strobe_d;
  // mode low: rise of write strobe; mode high: rise of strobe with direction low
  assign wr_fire = strobe_rise && !cs_n_s && (!mode_s || !rdrw_s);
  // mode low: read strobe low; mode high: direction high and strobe low
  assign read_req = !cs_n_s && (mode_s ? (rdrw_s && !strobe_s) : !rdrw_s);

  // ----------------------------------------
  // bus state, holding and local registers
  // ----------------------------------------
  logic [HPT_DATA_W-1:0] hold;
  logic [HPT_DATA_W-1:0] next_hold;
  logic [IRQ_LEN_W-1:0] irq_len;
  logic [IRQ_LEN_W-1:0] next_irq_len;
  logic [HPT_DATA_W-1:0] irq_cfg;
  logic [HPT_DATA_W-1:0] next_irq_cfg;
  logic next_tgt_we;
  logic [1:0] next_tgt_addr;
  logic [HPT_DATA_W-1:0] next_tgt_data;
  logic [HPT_DATA_W-1:0] next_p_out;
  logic next_p_oe_n;
  logic [1:0] rd_ch;
  logic [1:0] irq_ch;

  assign rd_ch = irq_cfg[HPT_CFG_RD_CH_LSB +: 2];
  assign irq_ch = irq_cfg[HPT_CFG_IRQ_CH_LSB +: 2];

  // write path: load holding or move it to the addressed target
  always_comb
  begin
    next_hold = hold;
    next_irq_len = irq_len;
    next_irq_cfg = irq_cfg;
    next_tgt_we = 1'b0;
    next_tgt_addr = tgt_addr;
    next_tgt_data = tgt_data;
    if (wr_fire && (loc == HPT_LOC_HOLD))
    begin
      next_hold = p_s;
    end
    else if (wr_fire)
    begin
      next_tgt_we = 1'b1;
      next_tgt_addr = loc;
      next_tgt_data = hold;
      if (loc == HPT_LOC_IRQ_LEN)
      begin
        next_irq_len = hold[IRQ_LEN_W-1:0];
      end
      else if (loc == HPT_LOC_IRQ_CFG)
      begin
        next_irq_cfg = hold;
      end
    end
  end

  // read path: drive the addressed location while a read is held
  always_comb
  begin
    next_p_oe_n = !read_req;
    if (loc == HPT_LOC_HOLD)
    begin
      next_p_out = hold;
    end
    else if (loc == HPT_LOC_IRQ_LEN)
    begin
      next_p_out = {{(HPT_DATA_W-IRQ_LEN_W){1'b0}}, irq_len};
    end
    else if (loc == HPT_LOC_IRQ_CFG)
    begin
      next_p_out = irq_cfg;
    end
    else if (chan_synced[rd_ch])
    begin
      next_p_out = chan_word(chan_data, rd_ch);
    end
    else
    begin
      next_p_out = 16'h0000;
    end
  end

  // register bus state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_d <= 1'b1;
      hold <= HPT_HOLD_RST;
      irq_len <= HPT_IRQ_LEN_RST[IRQ_LEN_W-1:0];
      irq_cfg <= HPT_IRQ_CFG_RST;
      tgt_we <= 1'b0;
      tgt_addr <= 2'h0;
      tgt_data <= 16'h0000;
      p_out <= 16'h0000;
      p_oe_n <= 1'b1;
    end
    else
    begin
      strobe_d <= strobe_s;
      hold <= next_hold;
      irq_len <= next_irq_len;
      irq_cfg <= next_irq_cfg;
      tgt_we <= next_tgt_we;
      tgt_addr <= next_tgt_addr;
      tgt_data <= next_tgt_data;
      p_out <= next_p_out;
      p_oe_n <= next_p_oe_n;
    end
  end

  // ----------------------------------------
  // new-data interrupt timer
  // ----------------------------------------
  logic irq_hit;
  logic [IRQ_LEN_W-1:0] irq_cnt;
  logic [IRQ_LEN_W-1:0] next_irq_cnt;
  logic next_new_data_irq;

  assign irq_hit = chan_new[irq_ch];

  // load programmed length (one if zero) on new data, then count down
  always_comb
  begin
    next_irq_cnt = irq_cnt;
    if (irq_hit)
    begin
      next_irq_cnt = (irq_len == '0) ? IRQ_LEN_W'(1) : irq_len;
    end
    else if (irq_cnt != '0)
    begin
      next_irq_cnt = irq_cnt - IRQ_LEN_W'(1);
    end
    next_new_data_irq = (next_irq_cnt != '0);
  end

  // register timer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_cnt <= '0;
      new_data_irq <= 1'b0;
    end
    else
    begin
      irq_cnt <= next_irq_cnt;
      new_data_irq <= next_new_data_irq;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence seq_move;
    wr_fire && (loc != HPT_LOC_HOLD);
  endsequence

  sequence seq_load;
    wr_fire && (loc == HPT_LOC_HOLD);
  endsequence

  oe_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    read_req |=> !p_oe_n)
    else $error("bus not driven during read");

  oe_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !read_req |=> p_oe_n)
    else $error("bus driven outside read");

  hold_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_load |=> (hold == $past(p_s)) && !tgt_we)
    else $error("holding register not loaded");

  target_move_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_move |=> tgt_we && (tgt_data == $past(hold)) ##1 !tgt_we || wr_fire)
    else $error("holding register not moved");

  addr_msb_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq_move |=> (tgt_addr == $past(addr_s[1:0])))
    else $error("target address wrong");

  no_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (strobe_rise && (cs_n_s || (mode_s && rdrw_s))) |=> !tgt_we && $stable(hold))
    else $error("write without valid strobe");

  irq_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_hit |=> new_data_irq)
    else $error("interrupt not raised");

  irq_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (new_data_irq && (irq_cnt == IRQ_LEN_W'(1)) && !irq_hit) |=> !new_data_irq)
    else $error("interrupt too long");

  unsync_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (loc == HPT_LOC_CHAN && !chan_synced[rd_ch]) |=> (p_out == 16'h0000))
    else $error("unsynchronised channel readable");

endmodule
`default_nettype wire

// ==== verif/hpt_host_model.sv ====
// host processor model driving the parallel port pins
`timescale 1ns/1ns
`default_nettype none
module hpt_host_model
  import hpt_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // device side of the bus
  input wire logic [HPT_DATA_W-1:0] p_out,
  input wire logic p_oe_n,
  // pins to the device
  output logic [HPT_DATA_W-1:0] p_in,
  output logic [HPT_ADDR_W-1:0] addr,
  output logic data_strobe,
  output logic rd_rw,
  output logic cs_n,
  output logic mode_sel
);
  logic drv = 1'b0;
  logic [HPT_DATA_W-1:0] dq = 16'h0000;

  // wire level: device, host, else inverse of last host word
  assign p_in = !p_oe_n ? p_out : (drv ? dq : ~dq);

  // idle pins, separate strobe style by default
  initial
  begin
    cs_n = 1'b1;
    data_strobe = 1'b1;
    rd_rw = 1'b1;
    addr = 3'h0;
    mode_sel = 1'b0;
  end

  // wait n edges, then move just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one write: strobe low, then rising edge, select held around it
  task automatic write(input logic md, input logic sel, input logic [2:0] a,
                       input logic [15:0] d);
    mode_sel = md;
    step(4);
    cs_n = ~sel;
    addr = a;
    dq = d;
    drv = 1'b1;
    rd_rw = ~md;
    data_strobe = 1'b0;
    step(5);
    data_strobe = 1'b1;
    step(5);
    cs_n = 1'b1;
    drv = 1'b0;
    rd_rw = 1'b1;
    step(5);
  endtask

  // one read: hold the read condition until the device drives, then release
  task automatic read(input logic md, input logic [2:0] a, output logic [15:0] d,
                      output logic ok);
    int i;
    mode_sel = md;
    step(4);
    cs_n = 1'b0;
    addr = a;
    rd_rw = md;
    data_strobe = ~md;
    for (i = 0; i < 20 && p_oe_n !== 1'b0; i++)
      step(1);
    step(2);
    d = p_out;
    ok = (p_oe_n === 1'b0);
    cs_n = 1'b1;
    rd_rw = 1'b1;
    data_strobe = 1'b1;
    for (i = 0; i < 20 && p_oe_n !== 1'b1; i++)
      step(1);
    ok = ok && (p_oe_n === 1'b1);
    step(3);
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the host port
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import hpt_pkg::*;
;
  logic clk_sys, rst_n, p_oe_n, data_strobe, rd_rw, cs_n, mode_sel;
  logic tgt_we, new_data_irq;
  logic [15:0] p_in, p_out, tgt_data, wd;
  logic [2:0] addr;
  logic [1:0] tgt_addr, wa;
  logic [63:0] chan_data;
  logic [3:0] chan_new, chan_synced;
  int error_cnt = 0;
  int checked = 0;
  int we_cnt = 0;
  int irq_cnt = 0;
  int n;

  // ----------------------------------------
  // clock, design and host model
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  hpt_host_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .p_in(p_in), .p_out(p_out),
    .p_oe_n(p_oe_n), .addr(addr), .data_strobe(data_strobe), .rd_rw(rd_rw),
    .cs_n(cs_n), .mode_sel(mode_sel), .chan_data(chan_data), .chan_new(chan_new),
    .chan_synced(chan_synced), .tgt_we(tgt_we), .tgt_addr(tgt_addr),
    .tgt_data(tgt_data), .new_data_irq(new_data_irq));

  hpt_host_model host (.clk_sys(clk_sys), .p_out(p_out), .p_oe_n(p_oe_n), .p_in(p_in),
    .addr(addr), .data_strobe(data_strobe), .rd_rw(rd_rw), .cs_n(cs_n),
    .mode_sel(mode_sel));

  // moves and interrupt cycles seen
  always @(posedge clk_sys)
  begin
    if (tgt_we === 1'b1)
    begin
      we_cnt++;
      wa = tgt_addr;
      wd = tgt_data;
    end
    if (new_data_irq === 1'b1)
      irq_cnt++;
  end

  // ----------------------------------------
  // report helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read a location and compare; a stuck handshake ends the run
  task automatic rd(input logic md, input logic [2:0] a, input logic [15:0] e,
                    input string nm);
    logic [15:0] d;
    logic ok;
    host.read(md, a, d, ok);
    if (!ok)
    begin
      error_cnt++;
      $display("[FAIL] %s handshake expected 1 seen 0", nm);
      end_sim();
    end
    else
    begin
      chk(nm, e, d);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("oe_n", 16'h0001, {15'h0, p_oe_n});
    chk("irq", 16'h0000, {15'h0, new_data_irq});
    rd(1'b0, 3'h1, HPT_IRQ_LEN_RST, "len_rst");
    rd(1'b0, 3'h2, HPT_IRQ_CFG_RST, "cfg_rst");
  endtask

  task automatic t_sep_write();
    host.write(1'b0, 1'b1, 3'h0, 16'hA5C3);
    rd(1'b0, 3'h4, 16'hA5C3, "hold");
    n = we_cnt;
    host.write(1'b0, 1'b1, 3'h5, 16'h0000);
    chk("moves", 16'(n + 1), 16'(we_cnt));
    chk("move_loc", 16'h0001, {14'h0, wa});
    chk("move_val", 16'hA5C3, wd);
  endtask

  task automatic t_single();
    host.write(1'b1, 1'b1, 3'h0, 16'h0006);
    host.write(1'b1, 1'b1, 3'h2, 16'h0000);
    chk("move_loc", 16'h0002, {14'h0, wa});
    rd(1'b1, 3'h2, 16'h0006, "cfg");
  endtask

  task automatic t_refuse();
    n = we_cnt;
    host.write(1'b0, 1'b0, 3'h0, 16'hFFFF);
    host.write(1'b0, 1'b0, 3'h1, 16'hFFFF);
    chk("moves", 16'(n), 16'(we_cnt));
    rd(1'b0, 3'h0, 16'h0006, "hold");
  endtask

  task automatic t_irq();
    host.write(1'b0, 1'b1, 3'h0, 16'h0003);
    host.write(1'b0, 1'b1, 3'h1, 16'h0000);
    n = irq_cnt;
    chan_new = 4'h4;
    @(posedge clk_sys);
    #1;
    chan_new = 4'h1;
    @(posedge clk_sys);
    #1;
    chan_new = 4'h0;
    repeat (12) @(posedge clk_sys);
    #1;
    chk("irq_len", 16'h0003, 16'(irq_cnt - n));
  endtask

  task automatic t_chan();
    chan_data = 64'h4444_3333_1234_1111;
    chan_synced = 4'h2;
    rd(1'b0, 3'h3, 16'h1234, "chan");
    chan_synced = 4'h0;
    rd(1'b1, 3'h7, 16'h0000, "chan_off");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    chan_data = 64'h0;
    chan_new = 4'h0;
    chan_synced = 4'h0;
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_reset();
    t_sep_write();
    t_single();
    t_refuse();
    t_irq();
    t_chan();
    end_sim();
  end
endmodule
`default_nettype wire
